// ===== otw_sw_regs.sv
// Overtemperature warning and switching frequency registers behind an AXI4-Lite slave
//
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
// Function
// - Warning flag sets after 100 ms continuous condition
// - Threshold widened to nine bits, zero on top
// - Unsigned compare against nine sensor MSBs
// - Condition when sensor reading below threshold
// - Threshold code linear, 3.125 mV per step
// - Six-bit code picks tabulated PWM frequency
module otw_sw_regs
  import otw_sw_pkg::*;
#(
  parameter int ADC_W = 12,
  parameter int DEBOUNCE_CYCLES = DEBOUNCE_CYC
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [ADC_W-1:0] thermal_resistor_sense,
  output logic temp_warning,
  output logic [FSW_W-1:0] active_freq_code,
  output logic [PER_W-1:0] pwm_period_cycles,
  output logic pwm_period_tick
);
  localparam int CNT_W = $clog2(DEBOUNCE_CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_MAX = CNT_W'(DEBOUNCE_CYCLES);

  logic [THR_W-1:0] thr_q;
  logic [FSW_W-1:0] fsw_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic aw_held_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic w_held_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic do_write;
  logic [CMP_W-1:0] thr9;
  logic [CMP_W-1:0] sense9;
  logic cond_q;
  logic [CNT_W-1:0] cnt_q;
  logic warn_q;
  logic [31:0] rd_val;
  logic rd_hit;

  // -----------------------------------------------------------------
  // AXI4-Lite write channels
  // -----------------------------------------------------------------
  assign s_axi_awready = !aw_held_q && !bvalid_q;
  assign s_axi_wready = !w_held_q && !bvalid_q;
  assign do_write = aw_held_q && w_held_q && !bvalid_q;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      aw_held_q <= 1'b0;
      awaddr_q <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_q <= 1'b1;
      awaddr_q <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held_q <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      w_held_q <= 1'b0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_q <= 1'b1;
      wdata_q <= s_axi_wdata;
      wstrb_q <= s_axi_wstrb;
    end else if (do_write) begin
      w_held_q <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else if (do_write) begin
      bvalid_q <= 1'b1;
      bresp_q <= (awaddr_q[ADDR_W-1:2] == THR_ADDR[ADDR_W-1:2] ||
                  awaddr_q[ADDR_W-1:2] == FSW_ADDR[ADDR_W-1:2]) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // -----------------------------------------------------------------
  // Configuration registers
  // -----------------------------------------------------------------
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      thr_q <= THR_RST;
    end else if (do_write && wstrb_q[0] && awaddr_q[ADDR_W-1:2] == THR_ADDR[ADDR_W-1:2]) begin
      thr_q <= wdata_q[THR_W-1:0];
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      fsw_q <= FSW_RST;
    end else if (do_write && wstrb_q[0] && awaddr_q[ADDR_W-1:2] == FSW_ADDR[ADDR_W-1:2]) begin
      fsw_q <= wdata_q[FSW_W-1:0];
    end
  end

  // -----------------------------------------------------------------
  // AXI4-Lite read channel
  // -----------------------------------------------------------------
  always_comb begin
    rd_val = '0;
    rd_hit = 1'b1;
    case (s_axi_araddr[ADDR_W-1:2])
      THR_ADDR[ADDR_W-1:2]: begin
        rd_val[THR_W-1:0] = thr_q;
      end
      FSW_ADDR[ADDR_W-1:2]: begin
        rd_val[FSW_W-1:0] = fsw_q;
      end
      STAT_ADDR[ADDR_W-1:2]: begin
        rd_val[STAT_WARN_BIT] = warn_q;
        rd_val[STAT_COND_BIT] = cond_q;
        rd_val[STAT_CODE_LSB +: FSW_W] = active_freq_code;
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  assign s_axi_arready = !rvalid_q;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_val;
      rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // -----------------------------------------------------------------
  // Warning compare and debounce
  // -----------------------------------------------------------------
  assign thr9 = {1'b0, thr_q};
  assign sense9 = thermal_resistor_sense[ADC_W-1 -: CMP_W];

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cond_q <= 1'b0;
    end else begin
      cond_q <= (sense9 < thr9);
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= '0;
    end else if (!cond_q) begin
      cnt_q <= '0;
    end else if (cnt_q != CNT_MAX) begin
      cnt_q <= cnt_q + CNT_W'(1);
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      warn_q <= 1'b0;
    end else begin
      warn_q <= cond_q && (cnt_q >= CNT_MAX - CNT_W'(1));
    end
  end

  assign temp_warning = warn_q;

  // -----------------------------------------------------------------
  // PWM period timer
  // -----------------------------------------------------------------
  freq_period_timer u_timer (
    .clock(clock),
    .arst_n(arst_n),
    .code_req(fsw_q),
    .code_act(active_freq_code),
    .period_len(pwm_period_cycles),
    .period_tick(pwm_period_tick)
  );

  // -----------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  logic [CNT_W-1:0] run_q;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      run_q <= '0;
    end else if (!cond_q) begin
      run_q <= '0;
    end else if (run_q != CNT_MAX) begin
      run_q <= run_q + CNT_W'(1);
    end
  end

  property p_warn_needs_run;
    $rose(warn_q) |-> $past(run_q) >= CNT_MAX - CNT_W'(1);
  endproperty
  a_warn_needs_run: assert property (p_warn_needs_run) else $error("warning set too early");

  property p_warn_after_run;
    cond_q && run_q == CNT_MAX - CNT_W'(1) |=> warn_q;
  endproperty
  a_warn_after_run: assert property (p_warn_after_run) else $error("warning not set after debounce");

  property p_cond_compare;
    ##1 cond_q == ($past(thermal_resistor_sense[ADC_W-1 -: CMP_W]) < {1'b0, $past(thr_q)});
  endproperty
  a_cond_compare: assert property (p_cond_compare) else $error("compare result wrong");

  property p_thr_msb_zero;
    $past(thermal_resistor_sense[ADC_W-1]) |-> !cond_q;
  endproperty
  a_thr_msb_zero: assert property (p_thr_msb_zero) else $error("threshold top bit set");

  property p_warn_implies_cond;
    warn_q |-> $past(cond_q) && $past(cond_q, 2);
  endproperty
  a_warn_implies_cond: assert property (p_warn_implies_cond) else $error("warning without condition");

  property p_thr_write;
    do_write && wstrb_q[0] && awaddr_q[ADDR_W-1:2] == THR_ADDR[ADDR_W-1:2] |=> thr_q == $past(wdata_q[THR_W-1:0]);
  endproperty
  a_thr_write: assert property (p_thr_write) else $error("threshold code not stored");

  property p_period_table;
    pwm_period_cycles == period_cycles(active_freq_code);
  endproperty
  a_period_table: assert property (p_period_table) else $error("period does not match code");

  property p_code_at_boundary;
    $changed(active_freq_code) |-> pwm_period_tick;
  endproperty
  a_code_at_boundary: assert property (p_code_at_boundary) else $error("code changed mid period");

  property p_bvalid_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bvalid_hold: assert property (p_bvalid_hold) else $error("write response dropped");

  property p_read_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read not answered");
endmodule
`default_nettype wire

// ===== otw_sw_pkg.sv
// Constants, register map and frequency table for the warning and switching frequency registers
package otw_sw_pkg;
  // -----------------------------------------------------------------
  // Clock and debounce timing
  // -----------------------------------------------------------------
  localparam int CLK_HZ = 10_000_000;
  localparam int DEBOUNCE_MS = 100;
  localparam int DEBOUNCE_CYC = (CLK_HZ / 1000) * DEBOUNCE_MS;

  // -----------------------------------------------------------------
  // Register map (indices; byte address is four times the index)
  // -----------------------------------------------------------------
  localparam int ADDR_W = 20;
  localparam logic [15:0] THR_IDX = 16'hfe1a;
  localparam logic [15:0] FSW_IDX = 16'hfe1b;
  localparam logic [15:0] STAT_IDX = 16'h0100;
  localparam logic [ADDR_W-1:0] THR_ADDR = {2'b00, THR_IDX, 2'b00};
  localparam logic [ADDR_W-1:0] FSW_ADDR = {2'b00, FSW_IDX, 2'b00};
  localparam logic [ADDR_W-1:0] STAT_ADDR = {2'b00, STAT_IDX, 2'b00};

  // -----------------------------------------------------------------
  // Fields and reset values
  // -----------------------------------------------------------------
  localparam int THR_W = 8;
  localparam int CMP_W = 9;
  localparam int FSW_W = 6;
  localparam logic [THR_W-1:0] THR_RST = 8'h00;
  localparam logic [FSW_W-1:0] FSW_RST = 6'h00;
  localparam int STAT_WARN_BIT = 0;
  localparam int STAT_COND_BIT = 1;
  localparam int STAT_CODE_LSB = 8;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // -----------------------------------------------------------------
  // Switching frequency table in units of 10 Hz
  // -----------------------------------------------------------------
  localparam int FREQ_N = 64;
  localparam int PER_W = 16;
  localparam int unsigned FREQ_10HZ [FREQ_N] = '{
    3005, 3255, 3551, 3906, 4340, 4883, 5206, 5580,
    6010, 6510, 7102, 7813, 8681, 9766, 10081, 10417,
    10776, 11161, 11574, 12019, 12500, 13021, 13587, 14205,
    14881, 15625, 16447, 17361, 18382, 19531, 19841, 20161,
    20492, 20833, 21186, 21552, 21930, 22321, 22727, 23148,
    23585, 24038, 24510, 25000, 25510, 26042, 26596, 27174,
    27778, 28409, 29070, 29762, 30488, 31250, 32051, 32895,
    33784, 34722, 35714, 36765, 37879, 39063, 40323, 40323
  };
  localparam int unsigned TEN_HZ = 10;

  // Nearest whole clock count for one PWM period
  function automatic logic [PER_W-1:0] period_cycles(input logic [FSW_W-1:0] code);
    int unsigned f;
    f = FREQ_10HZ[code] * TEN_HZ;
    return PER_W'((CLK_HZ + f / 2) / f);
  endfunction
endpackage

// ===== freq_period_timer.sv
// PWM period timer that swaps in a new frequency code only at a period boundary
`timescale 1ns/10ps
`default_nettype none
module freq_period_timer
  import otw_sw_pkg::*;
(
  input wire logic clock,
  input wire logic arst_n,
  input wire logic [FSW_W-1:0] code_req,
  output logic [FSW_W-1:0] code_act,
  output logic [PER_W-1:0] period_len,
  output logic period_tick
);
  localparam logic [PER_W-1:0] LEN_RST = period_cycles(FSW_RST);

  logic [PER_W-1:0] cnt_q;
  logic [PER_W-1:0] len_q;
  logic [FSW_W-1:0] code_q;
  logic tick_q;
  logic wrap;

  assign wrap = (cnt_q >= len_q - PER_W'(1));

  // -----------------------------------------------------------------
  // Period counter
  // -----------------------------------------------------------------
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= '0;
    end else if (wrap) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + PER_W'(1);
    end
  end

  // -----------------------------------------------------------------
  // Code and length taken over at the boundary only
  // -----------------------------------------------------------------
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      code_q <= FSW_RST;
      len_q <= LEN_RST;
    end else if (wrap) begin
      code_q <= code_req;
      len_q <= period_cycles(code_req);
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      tick_q <= 1'b0;
    end else begin
      tick_q <= wrap;
    end
  end

  assign code_act = code_q;
  assign period_len = len_q;
  assign period_tick = tick_q;
endmodule
`default_nettype wire

// ===== host_model.sv
// Host-side AXI4-Lite master model
`timescale 1ns/10ps
`default_nettype none
module host_model
  import otw_sw_pkg::*;
(
  input wire logic clock,
  output logic [ADDR_W-1:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [ADDR_W-1:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hf;
  end
  // Response 2'h1 marks a timeout
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] v, output logic [1:0] r);
    logic ka, kw, kb, fin;
    logic [1:0] rb;
    fin = 1'h0;
    r = 2'h1;
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    for (int n = 0; n < 50 && !fin; n++) begin
      @(negedge clock);
      ka = s_axi_awready;
      kw = s_axi_wready;
      kb = s_axi_bvalid;
      rb = s_axi_bresp;
      @(posedge clock);
      if (ka) s_axi_awvalid <= 1'h0;
      if (kw) s_axi_wvalid <= 1'h0;
      if (kb) begin
        s_axi_bready <= 1'h0;
        r = rb;
        fin = 1'h1;
      end
    end
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] v, output logic [1:0] r);
    logic ka, kb, fin;
    logic [1:0] rb;
    logic [31:0] dv;
    fin = 1'h0;
    r = 2'h1;
    v = '0;
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    for (int n = 0; n < 50 && !fin; n++) begin
      @(negedge clock);
      ka = s_axi_arready;
      kb = s_axi_rvalid;
      rb = s_axi_rresp;
      dv = s_axi_rdata;
      @(posedge clock);
      if (ka) s_axi_arvalid <= 1'h0;
      if (kb) begin
        s_axi_rready <= 1'h0;
        r = rb;
        v = dv;
        fin = 1'h1;
      end
    end
  endtask
endmodule
`default_nettype wire

// ===== tb_top.sv
// Testbench for the warning and switching frequency registers
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import otw_sw_pkg::*;
  logic clock, arst_n;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata, seed, d;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [11:0] thermal_resistor_sense;
  logic temp_warning, pwm_period_tick;
  logic [FSW_W-1:0] active_freq_code;
  logic [PER_W-1:0] pwm_period_cycles;
  int num_errors, checks_done, thr_m, fsw_m, t;
  int codes [4] = '{22, 63, 0, 5};
  otw_sw_regs #(.ADC_W(12), .DEBOUNCE_CYCLES(20)) uut (.clock, .arst_n, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .thermal_resistor_sense,
    .temp_warning, .active_freq_code, .pwm_period_cycles, .pwm_period_tick);
  host_model host (.clock, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);
  initial begin
    clock = 1'h0;
    forever #50 clock = ~clock;
  end
  // ----
  // Helpers
  // ----
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic int per(input int k);
    int f;
    f = FREQ_10HZ[k] * 10;
    return (CLK_HZ + f / 2) / f;
  endfunction
  task automatic end_of_test();
    $display("errors=%0d checks=%0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      num_errors++;
    end
  endtask
  task automatic hang();
    num_errors++;
    end_of_test();
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] v, input logic [1:0] er);
    host.wr(a, v, r);
    if (r === 2'h1) hang();
    chk(r, er);
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] ev, input logic [1:0] er);
    host.rd(a, d, r);
    if (r === 2'h1) hang();
    chk(r, er);
    chk(d, ev);
  endtask
  task automatic tick();
    for (int n = 0; n <= 400; n++) begin
      @(negedge clock);
      if (pwm_period_tick === 1'h1) return;
    end
    hang();
  endtask
  // Sensor top nine bits, random low bits
  task automatic warn(input int top, input int hold, input logic exp);
    d = xs();
    @(posedge clock);
    thermal_resistor_sense <= {top[8:0], d[2:0]};
    repeat (hold) @(posedge clock);
    @(negedge clock);
    chk(temp_warning, exp);
  endtask
  // ----
  // Main sequence
  // ----
  initial begin
    seed = 32'h0001_5284;
    arst_n = 1'h0;
    thermal_resistor_sense = '1;
    repeat (8) @(posedge clock);
    arst_n <= 1'h1;
    @(negedge clock);
    chk(active_freq_code, '0);
    chk(pwm_period_cycles, per(0));
    rd(THR_ADDR, 0, RESP_OKAY);
    rd(FSW_ADDR, 0, RESP_OKAY);
    rd(STAT_ADDR, 0, RESP_OKAY);
    $display("reset done");
    for (int i = 0; i < 4; i++) begin
      d = xs();
      thr_m = 3 + d[15:0] % 248;
      wr(THR_ADDR, {d[31:8], thr_m[7:0]}, RESP_OKAY);
      rd(THR_ADDR, thr_m, RESP_OKAY);
    end
    wr(20'h0_0010, d, RESP_SLVERR);
    rd(20'h0_0010, 0, RESP_SLVERR);
    wr(STAT_ADDR, d, RESP_SLVERR);
    rd(THR_ADDR, thr_m, RESP_OKAY);
    $display("registers done");
    codes[3] = xs() % 64;
    foreach (codes[i]) begin
      fsw_m = codes[i];
      wr(FSW_ADDR, 32'hffff_ffc0 | fsw_m, RESP_OKAY);
      rd(FSW_ADDR, fsw_m, RESP_OKAY);
      tick();
      tick();
      chk(active_freq_code, fsw_m);
      t = 0;
      do begin
        @(negedge clock);
        t++;
      end while (pwm_period_tick !== 1'h1 && t < 400);
      chk(t, per(fsw_m));
      chk(pwm_period_cycles, per(fsw_m));
    end
    $display("frequency done");
    for (int i = 0; i < 2; i++) begin
      thr_m = (i == 0) ? 8'hfa : 3 + xs() % 248;
      wr(THR_ADDR, thr_m, RESP_OKAY);
      warn(thr_m - 1, 18, 1'h0);
      warn(thr_m - 1, 5, 1'h1);
      rd(STAT_ADDR, (fsw_m << 8) | 3, RESP_OKAY);
      warn(thr_m, 3, 1'h0);
      warn(thr_m, 24, 1'h0);
      warn(thr_m - 1, 12, 1'h0);
      warn(thr_m, 1, 1'h0);
      warn(thr_m - 1, 18, 1'h0);
      warn(thr_m - 1, 5, 1'h1);
      warn(9'h1ff, 26, 1'h0);
      warn(9'h100, 26, 1'h0);
    end
    $display("warning done");
    warn(thr_m - 1, 24, 1'h1);
    @(posedge clock);
    arst_n <= 1'h0;
    @(negedge clock);
    chk(temp_warning, 1'h0);
    repeat (2) @(posedge clock);
    arst_n <= 1'h1;
    @(negedge clock);
    chk(temp_warning, 1'h0);
    chk(active_freq_code, '0);
    chk(pwm_period_cycles, per(0));
    rd(THR_ADDR, 0, RESP_OKAY);
    rd(FSW_ADDR, 0, RESP_OKAY);
    rd(STAT_ADDR, 0, RESP_OKAY);
    $display("second reset done");
    end_of_test();
  end
endmodule
`default_nettype wire
